// file: rtl/cmp_ctrl_top.sv
`timescale 1ns/1ps
module cmp_ctrl_top (
  input  wire logic                       i_sys_clk,    // 20 MHz system clock
  input  wire logic                       i_srst,       // Sync reset, high
  input  wire logic [1:0]                 i_cmp_raw,    // Analog outputs
  input  wire logic [cmp_pkg::ADDR_W-1:0] i_awaddr,     // Write address
  input  wire logic                       i_awvalid,    // Write addr valid
  output logic                            o_awready,    // Write addr ready
  input  wire logic [31:0]                i_wdata,      // Write data
  input  wire logic [3:0]                 i_wstrb,      // Byte strobes
  input  wire logic                       i_wvalid,     // Write data valid
  output logic                            o_wready,     // Write data ready
  output logic [1:0]                      o_bresp,      // Write response
  output logic                            o_bvalid,     // Response valid
  input  wire logic                       i_bready,     // Response ready
  input  wire logic [cmp_pkg::ADDR_W-1:0] i_araddr,     // Read address
  input  wire logic                       i_arvalid,    // Read addr valid
  output logic                            o_arready,    // Read addr ready
  output logic [31:0]                     o_rdata,      // Read data
  output logic [1:0]                      o_rresp,      // Read response
  output logic                            o_rvalid,     // Read data valid
  input  wire logic                       i_rready,     // Read data ready
  output logic [1:0]                      o_cmp_on,     // Analog enables
  output logic [1:0][1:0]                 o_pos_hyst,   // Positive hyst codes
  output logic [1:0][1:0]                 o_neg_hyst,   // Negative hyst codes
  output logic [1:0][1:0]                 o_speed_sel,  // Speed/power codes
  output logic [1:0]                      o_pin_out,    // Crossbar outputs
  output logic [1:0]                      o_cmp_irq,    // Per comparator irq
  output logic                            o_irq         // Masked status irq
);
  // Write channel state
  cmp_pkg::wr_state_e ws_r;    // Write state
  logic               aw_held_r;  // Address captured
  logic               w_held_r;   // Data captured
  logic [7:0]         wr_idx_r;   // Write index
  logic [7:0]         wr_dat_r;   // Write byte
  logic               wr_be_r;    // Low byte enabled
  logic               wr_go;      // Both halves held
  logic               wr_en;      // Register write strobe
  logic               wr_hit;     // Index is mapped
  // Read channel state
  cmp_pkg::rd_state_e rs_r;       // Read state
  logic [7:0]         rd_idx_r;   // Read index
  logic [7:0]         rd_val;     // Looked-up value
  logic               rd_hit;     // Index is mapped
  // Per comparator storage
  logic               on_r  [2];  // Enable bits
  logic [1:0]         hyp_r [2];  // Positive hysteresis
  logic [1:0]         hyn_r [2];  // Negative hysteresis
  logic               rie_r [2];  // Rise irq enable
  logic               fie_r [2];  // Fall irq enable
  logic [1:0]         md_r  [2];  // Speed select
  logic [7:0]         ctl_rd [2]; // Control readback
  logic [7:0]         md_rd  [2]; // Mode readback
  logic [1:0]         rflag;      // Rise flags
  logic [1:0]         fflag;      // Fall flags
  logic [1:0]         lvl;        // Synced levels
  wire  [3:0]         edge_evt;   // Event pulses
  logic [3:0]         irq_stat;   // Status readback
  logic [3:0]         irq_mask;   // Mask readback

  // Write takes address and data in either order
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      ws_r      <= cmp_pkg::WS_IDLE;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= cmp_pkg::RESP_OKAY;
      wr_idx_r  <= 8'h00;
      wr_dat_r  <= 8'h00;
      wr_be_r   <= 1'b0;
    end
    else
    begin
      unique case (ws_r)
        cmp_pkg::WS_IDLE:
        begin
          // Capture address
          if (i_awvalid && o_awready)
          begin
            wr_idx_r  <= i_awaddr[cmp_pkg::ADDR_W-1:cmp_pkg::IDX_LSB];
            aw_held_r <= 1'b1;
            o_awready <= 1'b0;
          end
          // Capture data
          if (i_wvalid && o_wready)
          begin
            wr_dat_r <= i_wdata[7:0];
            wr_be_r  <= i_wstrb[0];
            w_held_r <= 1'b1;
            o_wready <= 1'b0;
          end
          // Perform write and answer
          if (wr_go)
          begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            o_bvalid  <= 1'b1;
            o_bresp   <= wr_hit ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
            ws_r      <= cmp_pkg::WS_RESP;
          end
        end
        cmp_pkg::WS_RESP:
        begin
          // Wait for response handshake
          if (i_bready)
          begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            ws_r      <= cmp_pkg::WS_IDLE;
          end
        end
      endcase
    end
  end

  assign wr_go = aw_held_r & w_held_r & (ws_r == cmp_pkg::WS_IDLE);
  assign wr_en = wr_go & wr_be_r;

  // Decode of mapped write indexes
  always_comb
  begin
    unique case (wr_idx_r)
      cmp_pkg::IDX_CMP0_CTRL, cmp_pkg::IDX_CMP1_CTRL,
      cmp_pkg::IDX_CMP0_MODE, cmp_pkg::IDX_CMP1_MODE,
      cmp_pkg::IDX_IRQ_STAT,  cmp_pkg::IDX_IRQ_MASK: wr_hit = 1'b1;
      default:                                      wr_hit = 1'b0;
    endcase
  end

  // Read: take address, look up, answer
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      rs_r      <= cmp_pkg::RS_IDLE;
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= cmp_pkg::RESP_OKAY;
      rd_idx_r  <= 8'h00;
    end
    else
    begin
      unique case (rs_r)
        cmp_pkg::RS_IDLE:
        begin
          if (i_arvalid)
          begin
            rd_idx_r  <= i_araddr[cmp_pkg::ADDR_W-1:cmp_pkg::IDX_LSB];
            o_arready <= 1'b0;
            rs_r      <= cmp_pkg::RS_LOOK;
          end
        end
        cmp_pkg::RS_LOOK:
        begin
          // Unmapped reads return zero with error
          o_rdata  <= {24'h00_0000, rd_val};
          o_rresp  <= rd_hit ? cmp_pkg::RESP_OKAY : cmp_pkg::RESP_SLVERR;
          o_rvalid <= 1'b1;
          rs_r     <= cmp_pkg::RS_RESP;
        end
        cmp_pkg::RS_RESP:
        begin
          if (i_rready)
          begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
            rs_r      <= cmp_pkg::RS_IDLE;
          end
        end
      endcase
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_hit = 1'b1;
    unique case (rd_idx_r)
      cmp_pkg::IDX_CMP0_CTRL: rd_val = ctl_rd[0];
      cmp_pkg::IDX_CMP1_CTRL: rd_val = ctl_rd[1];
      cmp_pkg::IDX_CMP0_MODE: rd_val = md_rd[0];
      cmp_pkg::IDX_CMP1_MODE: rd_val = md_rd[1];
      cmp_pkg::IDX_IRQ_STAT:  rd_val = {4'h0, irq_stat};
      cmp_pkg::IDX_IRQ_MASK:  rd_val = {4'h0, irq_mask};
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One slice per comparator
  for (genvar n = 0; n < cmp_pkg::NUM_CMP; n++)
  begin : g_cmp
    localparam logic [7:0] CI = (n == 0) ? cmp_pkg::IDX_CMP0_CTRL : cmp_pkg::IDX_CMP1_CTRL;
    localparam logic [7:0] MI = (n == 0) ? cmp_pkg::IDX_CMP0_MODE : cmp_pkg::IDX_CMP1_MODE;
    cmp_evt_if evt ();          // Link to edge unit
    logic      ctl_wr;          // Control write strobe
    logic      md_wr;           // Mode write strobe

    assign ctl_wr = wr_en && (wr_idx_r == CI);
    assign md_wr  = wr_en && (wr_idx_r == MI);

    // Writing zero to a flag clears it
    assign evt.clr_rise = ctl_wr & ~wr_dat_r[cmp_pkg::CTL_RISE];
    assign evt.clr_fall = ctl_wr & ~wr_dat_r[cmp_pkg::CTL_FALL];

    cmp_edge_unit u_edge (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_raw     (i_cmp_raw[n]),
      .evt       (evt.unit)
    );

    // Control register fields
    always_ff @(posedge i_sys_clk)
    begin
      if (i_srst)
      begin
        on_r[n]  <= cmp_pkg::CTRL_RST[cmp_pkg::CTL_ON];
        hyp_r[n] <= cmp_pkg::CTRL_RST[cmp_pkg::CTL_HYP +: 2];
        hyn_r[n] <= cmp_pkg::CTRL_RST[cmp_pkg::CTL_HYN +: 2];
      end
      else if (ctl_wr)
      begin
        on_r[n]  <= wr_dat_r[cmp_pkg::CTL_ON];
        hyp_r[n] <= wr_dat_r[cmp_pkg::CTL_HYP +: 2];
        hyn_r[n] <= wr_dat_r[cmp_pkg::CTL_HYN +: 2];
      end
    end

    // Mode register; unused pairs never stored
    always_ff @(posedge i_sys_clk)
    begin
      if (i_srst)
      begin
        rie_r[n] <= cmp_pkg::MODE_RST[cmp_pkg::MD_RIE];
        fie_r[n] <= cmp_pkg::MODE_RST[cmp_pkg::MD_FIE];
        md_r[n]  <= cmp_pkg::MODE_RST[cmp_pkg::MD_SEL +: 2];
      end
      else if (md_wr)
      begin
        rie_r[n] <= wr_dat_r[cmp_pkg::MD_RIE];
        fie_r[n] <= wr_dat_r[cmp_pkg::MD_FIE];
        md_r[n]  <= wr_dat_r[cmp_pkg::MD_SEL +: 2];
      end
    end

    // Readback; output state bit is read only
    always_comb
    begin
      ctl_rd[n] = 8'h00;
      ctl_rd[n][cmp_pkg::CTL_ON]         = on_r[n];
      ctl_rd[n][cmp_pkg::CTL_OUT]        = evt.level;
      ctl_rd[n][cmp_pkg::CTL_RISE]       = evt.rise_flag;
      ctl_rd[n][cmp_pkg::CTL_FALL]       = evt.fall_flag;
      ctl_rd[n][cmp_pkg::CTL_HYP +: 2]   = hyp_r[n];
      ctl_rd[n][cmp_pkg::CTL_HYN +: 2]   = hyn_r[n];
      md_rd[n] = 8'h00;
      md_rd[n][cmp_pkg::MD_RIE]          = rie_r[n];
      md_rd[n][cmp_pkg::MD_FIE]          = fie_r[n];
      md_rd[n][cmp_pkg::MD_SEL +: 2]     = md_r[n];
    end

    // Gated edge interrupt and pin output
    always_ff @(posedge i_sys_clk)
    begin
      if (i_srst)
      begin
        o_cmp_irq[n] <= 1'b0;
        o_pin_out[n] <= 1'b0;
      end
      else
      begin
        o_cmp_irq[n] <= (evt.rise_flag & rie_r[n]) | (evt.fall_flag & fie_r[n]);
        o_pin_out[n] <= on_r[n] & evt.level;
      end
    end

    assign rflag[n]            = evt.rise_flag;
    assign fflag[n]            = evt.fall_flag;
    assign lvl[n]              = evt.level;
    assign edge_evt[2*n]       = evt.rise_evt;
    assign edge_evt[2*n+1]     = evt.fall_evt;
    assign o_cmp_on[n]         = on_r[n];
    assign o_pos_hyst[n]       = hyp_r[n];
    assign o_neg_hyst[n]       = hyn_r[n];
    assign o_speed_sel[n]      = md_r[n];
  end

  irq_status_unit u_irq (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_evt      (edge_evt),
    .i_w1c_stb  (wr_en && (wr_idx_r == cmp_pkg::IDX_IRQ_STAT)),
    .i_mask_stb (wr_en && (wr_idx_r == cmp_pkg::IDX_IRQ_MASK)),
    .i_wdata    (wr_dat_r[3:0]),
    .o_stat     (irq_stat),
    .o_mask     (irq_mask),
    .o_irq      (o_irq)
  );

  property p_rise_gate0;
    @(posedge i_sys_clk) disable iff (i_srst) o_cmp_irq[0] |-> $past(rflag[0] & rie_r[0]) ||
      $past(fflag[0] & fie_r[0]);
  endproperty
  a_rise_gate0: assert property (p_rise_gate0) else $error("cmp0 irq without cause");
  property p_fall_gate0;
    @(posedge i_sys_clk) disable iff (i_srst) (fflag[0] && fie_r[0]) |=> o_cmp_irq[0];
  endproperty
  a_fall_gate0: assert property (p_fall_gate0) else $error("cmp0 fall irq missing");
  property p_gate1;
    @(posedge i_sys_clk) disable iff (i_srst) (!rie_r[1] && !fie_r[1]) |=> !o_cmp_irq[1];
  endproperty
  a_gate1: assert property (p_gate1) else $error("cmp1 irq while disabled");
  property p_irq_or;
    @(posedge i_sys_clk) disable iff (i_srst)
      (rflag[1] && rie_r[1]) |=> o_cmp_irq[1];
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("cmp1 rise irq missing");
  property p_pin_low;
    @(posedge i_sys_clk) disable iff (i_srst) !on_r[1] |=> !o_pin_out[1];
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven while off");
  property p_unused_zero;
    @(posedge i_sys_clk) disable iff (i_srst)
      (o_rvalid && rd_idx_r == cmp_pkg::IDX_CMP1_MODE) |-> (o_rdata[7:6] == 2'b00 &&
      o_rdata[3:2] == 2'b00);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");
  property p_out_bit;
    @(posedge i_sys_clk) disable iff (i_srst)
      ($rose(o_rvalid) && rd_idx_r == cmp_pkg::IDX_CMP1_CTRL) |-> o_rdata[6] == $past(lvl[1]);
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("result bit mismatch");
  property p_on_reset;
    @(posedge i_sys_clk) $past(i_srst) |-> !o_cmp_on[0] && !o_cmp_on[1];
  endproperty
  a_on_reset: assert property (p_on_reset) else $error("enable not cleared");
  property p_speed_wr;
    @(posedge i_sys_clk) disable iff (i_srst)
      (wr_en && wr_idx_r == cmp_pkg::IDX_CMP1_MODE) |=> o_speed_sel[1] == $past(wr_dat_r[1:0]);
  endproperty
  a_speed_wr: assert property (p_speed_wr) else $error("speed select not written");
endmodule  // cmp_ctrl_top

// file: rtl/cmp_edge_unit.sv
`timescale 1ns/1ps
module cmp_edge_unit (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_srst,     // Sync reset
  input  wire logic i_raw,      // Analog comparator output
  cmp_evt_if.unit   evt         // Flags toward registers
);
  logic sync1_r;  // First sync stage
  logic sync2_r;  // Second sync stage
  logic prev_r;   // Last synced value
  logic rise_r;   // Rise flag
  logic fall_r;   // Fall flag

  // Two-stage synchroniser and history
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= i_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign evt.level    = sync2_r;
  assign evt.rise_evt = sync2_r & ~prev_r;
  assign evt.fall_evt = ~sync2_r & prev_r;

  // Sticky flags; a new edge beats a clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
    else
    begin
      rise_r <= evt.rise_evt | (rise_r & ~evt.clr_rise);
      fall_r <= evt.fall_evt | (fall_r & ~evt.clr_fall);
    end
  end

  assign evt.rise_flag = rise_r;
  assign evt.fall_flag = fall_r;

  property p_rise_set;
    @(posedge i_sys_clk) disable iff (i_srst) $rose(sync2_r) |=> rise_r;
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rise flag not set");
  property p_fall_hold;
    @(posedge i_sys_clk) disable iff (i_srst) (fall_r && !evt.clr_fall) |=> fall_r;
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("fall flag lost");
  property p_sync_lat;
    @(posedge i_sys_clk) disable iff (i_srst) $rose(sync1_r) |=> sync2_r ##1 rise_r;
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("edge latency wrong");
endmodule  // cmp_edge_unit

// file: rtl/cmp_evt_if.sv
`timescale 1ns/1ps
interface cmp_evt_if;
  logic clr_rise;   // Software clears rise flag
  logic clr_fall;   // Software clears fall flag
  logic level;      // Synchronised output state
  logic rise_flag;  // Sticky rise flag
  logic fall_flag;  // Sticky fall flag
  logic rise_evt;   // Rise seen this cycle
  logic fall_evt;   // Fall seen this cycle
  modport unit (input clr_rise, clr_fall,
                output level, rise_flag, fall_flag, rise_evt, fall_evt);
  modport ctl  (output clr_rise, clr_fall,
                input level, rise_flag, fall_flag, rise_evt, fall_evt);
endinterface

// file: rtl/cmp_pkg.sv
package cmp_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CMP1_CTRL = 8'h9a;
  localparam logic [7:0] IDX_CMP0_CTRL = 8'h9b;
  localparam logic [7:0] IDX_CMP1_MODE = 8'h9c;
  localparam logic [7:0] IDX_CMP0_MODE = 8'h9d;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'ha0;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'ha1;
  // Bus address layout
  localparam int ADDR_W  = 10;
  localparam int IDX_LSB = 2;
  // Control register fields
  localparam int CTL_ON   = 7;
  localparam int CTL_OUT  = 6;
  localparam int CTL_RISE = 5;
  localparam int CTL_FALL = 4;
  localparam int CTL_HYP  = 2;
  localparam int CTL_HYN  = 0;
  // Mode register fields
  localparam int MD_RIE = 5;
  localparam int MD_FIE = 4;
  localparam int MD_SEL = 0;
  // Reset values
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] MODE_RST     = 8'h02;
  localparam logic [3:0] IRQ_STAT_RST = 4'h0;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // Counts
  localparam int NUM_CMP = 2;
  localparam int NUM_EVT = 4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Bus channel states
  typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} wr_state_e;
  typedef enum logic [2:0] {RS_IDLE = 3'b001, RS_LOOK = 3'b010, RS_RESP = 3'b100} rd_state_e;
endpackage

// file: rtl/irq_status_unit.sv
`timescale 1ns/1ps
module irq_status_unit (
  input  wire logic       i_sys_clk,  // System clock
  input  wire logic       i_srst,     // Sync reset
  input  wire logic [3:0] i_evt,      // Edge event pulses
  input  wire logic       i_w1c_stb,  // Status write
  input  wire logic       i_mask_stb, // Mask write
  input  wire logic [3:0] i_wdata,    // Write data
  output logic      [3:0] o_stat,     // Sticky status
  output logic      [3:0] o_mask,     // Mask register
  output logic            o_irq       // Level interrupt
);
  logic [3:0] stat_nxt;  // Next status

  // Set wins over a write-one clear
  always_comb
  begin
    stat_nxt = o_stat & ~({4{i_w1c_stb}} & i_wdata);
    stat_nxt = stat_nxt | i_evt;
  end

  // Status register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_stat <= cmp_pkg::IRQ_STAT_RST;
    else
      o_stat <= stat_nxt;
  end

  // Mask register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_mask <= cmp_pkg::IRQ_MASK_RST;
    else if (i_mask_stb)
      o_mask <= i_wdata;
  end

  // Interrupt output
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_irq <= 1'b0;
    else
      o_irq <= |(o_stat & o_mask);
  end

  property p_stat_sticky;
    @(posedge i_sys_clk) disable iff (i_srst) (|i_evt) |=> ((o_stat & $past(i_evt)) != 4'h0);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status event lost");
endmodule  // irq_status_unit

// file: testbench/comparator_edge_irq_control_tb_top.sv
`timescale 1ns/1ps
module comparator_edge_irq_control_tb_top;
  // Clock, reset and stimulus nets
  logic                       i_sys_clk;    // System clock
  logic                       i_srst;       // Sync reset
  logic [1:0]                 i_cmp_raw;    // Analog outputs
  logic [cmp_pkg::ADDR_W-1:0] i_awaddr;     // Write address
  logic                       i_awvalid;    // Write addr valid
  logic [31:0]                i_wdata;      // Write data
  logic [3:0]                 i_wstrb;      // Byte strobes
  logic                       i_wvalid;     // Write data valid
  logic                       i_bready;     // Response ready
  logic [cmp_pkg::ADDR_W-1:0] i_araddr;     // Read address
  logic                       i_arvalid;    // Read addr valid
  logic                       i_rready;     // Read data ready
  // Design outputs
  logic                       o_awready;    // Write addr ready
  logic                       o_wready;     // Write data ready
  logic [1:0]                 o_bresp;      // Write response
  logic                       o_bvalid;     // Response valid
  logic                       o_arready;    // Read addr ready
  logic [31:0]                o_rdata;      // Read data
  logic [1:0]                 o_rresp;      // Read response
  logic                       o_rvalid;     // Read data valid
  logic [1:0]                 o_cmp_on;     // Analog enables
  logic [1:0][1:0]            o_pos_hyst;   // Positive hyst codes
  logic [1:0][1:0]            o_neg_hyst;   // Negative hyst codes
  logic [1:0][1:0]            o_speed_sel;  // Speed codes
  logic [1:0]                 o_pin_out;    // Crossbar outputs
  logic [1:0]                 o_cmp_irq;    // Per comparator irq
  logic                       o_irq;        // Masked status irq
  // Score keeping
  int                         failures;     // Mismatch count
  int                         cmp_count;    // Comparison count

  // Device under test
  cmp_ctrl_top cmp_ctrl_top_i (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cmp_raw(i_cmp_raw),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_cmp_on(o_cmp_on), .o_pos_hyst(o_pos_hyst), .o_neg_hyst(o_neg_hyst),
    .o_speed_sel(o_speed_sel), .o_pin_out(o_pin_out), .o_cmp_irq(o_cmp_irq),
    .o_irq(o_irq)
  );

  // 20 MHz clock
  always
  begin
    #25;
    i_sys_clk = ~i_sys_clk;
  end

  // Verdict and end of run
  task automatic close_out;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Wait whole cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write; address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
    logic [1:0] resp;
    bit         done;
    done = 1'b0;
    resp = 2'bxx;
    @(posedge i_sys_clk);
    i_awaddr  <= {idx, 2'b00};
    i_awvalid <= 1'b1;
    i_wdata   <= {24'h00_0000, d};
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (i_bready && o_bvalid)
      begin
        resp = o_bresp;
        i_bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk({30'h0000_0000, resp}, {30'h0000_0000, exp});
  endtask

  // Register read with expected data and response
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] eresp);
    logic [31:0] data;
    logic [1:0]  resp;
    bit          done;
    done = 1'b0;
    @(posedge i_sys_clk);
    i_araddr  <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (i_rready && o_rvalid)
      begin
        data = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk(data, {24'h00_0000, exp});
    chk({30'h0000_0000, resp}, {30'h0000_0000, eresp});
  endtask

  // Cut a hang short
  initial
  begin
    cyc(5000);
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    logic [7:0] idx_tab [6];
    logic [7:0] rst_tab [6];
    idx_tab = '{cmp_pkg::IDX_CMP1_CTRL, cmp_pkg::IDX_CMP0_CTRL, cmp_pkg::IDX_CMP1_MODE,
                cmp_pkg::IDX_CMP0_MODE, cmp_pkg::IDX_IRQ_STAT, cmp_pkg::IDX_IRQ_MASK};
    rst_tab = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00};
    failures = 0;
    cmp_count = 0;
    i_sys_clk = 1'b0;
    i_srst = 1'b1;
    i_cmp_raw = 2'b00;
    i_awaddr = '0;
    i_awvalid = 1'b0;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hf;
    i_wvalid = 1'b0;
    i_bready = 1'b0;
    i_araddr = '0;
    i_arvalid = 1'b0;
    i_rready = 1'b0;
    cyc(12);
    i_srst <= 1'b0;
    // Reset values of every register
    for (int k = 0; k < 6; k++)
      rd(idx_tab[k], rst_tab[k], cmp_pkg::RESP_OKAY);
    chk(32'(o_speed_sel), 32'h0000_000a);
    chk(32'(o_cmp_on), 32'h0000_0000);
    // Every speed code, unused mode bits stuck at zero
    for (int c = 0; c < 4; c++)
    begin
      wr(cmp_pkg::IDX_CMP1_MODE, 8'hcc | 8'(c), cmp_pkg::RESP_OKAY);
      rd(cmp_pkg::IDX_CMP1_MODE, 8'(c), cmp_pkg::RESP_OKAY);
      chk(32'(o_speed_sel[1]), 32'(c));
    end
    wr(cmp_pkg::IDX_CMP0_MODE, 8'hff, cmp_pkg::RESP_OKAY);
    rd(cmp_pkg::IDX_CMP0_MODE, 8'h33, cmp_pkg::RESP_OKAY);
    // Every hysteresis code, the two fields independent
    for (int c = 0; c < 4; c++)
    begin
      wr(cmp_pkg::IDX_CMP1_CTRL, 8'((c << 2) | (3 - c)), cmp_pkg::RESP_OKAY);
      rd(cmp_pkg::IDX_CMP1_CTRL, 8'((c << 2) | (3 - c)), cmp_pkg::RESP_OKAY);
      chk(32'(o_pos_hyst[1]), 32'(c));
      chk(32'(o_neg_hyst[1]), 32'(3 - c));
    end
    // Comparator 0 rising edge, rise enable only
    wr(cmp_pkg::IDX_CMP0_MODE, 8'h20, cmp_pkg::RESP_OKAY);
    wr(cmp_pkg::IDX_CMP0_CTRL, 8'h80, cmp_pkg::RESP_OKAY);
    chk(32'(o_cmp_on), 32'h0000_0001);
    i_cmp_raw <= 2'b01;
    cyc(6);
    chk(32'(o_cmp_irq), 32'h0000_0001);
    chk(32'(o_pin_out), 32'h0000_0001);
    rd(cmp_pkg::IDX_CMP0_CTRL, 8'he0, cmp_pkg::RESP_OKAY);
    wr(cmp_pkg::IDX_CMP0_MODE, 8'h00, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_cmp_irq), 32'h0000_0000);
    // Falling edge while fall enable is off, then on
    i_cmp_raw <= 2'b00;
    cyc(6);
    chk(32'(o_cmp_irq), 32'h0000_0000);
    rd(cmp_pkg::IDX_CMP0_CTRL, 8'hb0, cmp_pkg::RESP_OKAY);
    wr(cmp_pkg::IDX_CMP0_MODE, 8'h10, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_cmp_irq), 32'h0000_0001);
    // Clear rise by writing zero; a written one leaves fall set
    wr(cmp_pkg::IDX_CMP0_CTRL, 8'h90, cmp_pkg::RESP_OKAY);
    rd(cmp_pkg::IDX_CMP0_CTRL, 8'h90, cmp_pkg::RESP_OKAY);
    wr(cmp_pkg::IDX_CMP0_CTRL, 8'h80, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_cmp_irq), 32'h0000_0000);
    // Disabled comparator keeps its pin low
    wr(cmp_pkg::IDX_CMP0_CTRL, 8'h00, cmp_pkg::RESP_OKAY);
    i_cmp_raw <= 2'b01;
    cyc(6);
    chk(32'(o_pin_out), 32'h0000_0000);
    // Comparator 1 result bit and its own enables
    wr(cmp_pkg::IDX_CMP1_CTRL, 8'h80, cmp_pkg::RESP_OKAY);
    i_cmp_raw <= 2'b11;
    cyc(6);
    rd(cmp_pkg::IDX_CMP1_CTRL, 8'he0, cmp_pkg::RESP_OKAY);
    chk(32'(o_cmp_irq), 32'h0000_0000);
    wr(cmp_pkg::IDX_CMP1_MODE, 8'h10, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_cmp_irq), 32'h0000_0000);
    i_cmp_raw <= 2'b01;
    cyc(6);
    chk(32'(o_cmp_irq), 32'h0000_0002);
    rd(cmp_pkg::IDX_CMP1_CTRL, 8'hb0, cmp_pkg::RESP_OKAY);
    // Rise enable alone passes the standing rise flag
    wr(cmp_pkg::IDX_CMP1_MODE, 8'h20, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_cmp_irq), 32'h0000_0002);
    // Status, mask and write-one-to-clear
    rd(cmp_pkg::IDX_IRQ_STAT, 8'h0f, cmp_pkg::RESP_OKAY);
    chk(32'(o_irq), 32'h0000_0000);
    wr(cmp_pkg::IDX_IRQ_MASK, 8'h04, cmp_pkg::RESP_OKAY);
    cyc(2);
    chk(32'(o_irq), 32'h0000_0001);
    wr(cmp_pkg::IDX_IRQ_STAT, 8'h04, cmp_pkg::RESP_OKAY);
    rd(cmp_pkg::IDX_IRQ_STAT, 8'h0b, cmp_pkg::RESP_OKAY);
    chk(32'(o_irq), 32'h0000_0000);
    // Unmapped place refused both ways
    wr(8'h80, 8'h5a, cmp_pkg::RESP_SLVERR);
    rd(8'h80, 8'h00, cmp_pkg::RESP_SLVERR);
    close_out();
  end
endmodule // comparator_edge_irq_control_tb_top
